// ---- rocp_regs.svh ----
// offsets, field positions and reset values of the ram output-clear block
// assumes inclusion by bare name from the package and the design modules
`ifndef ROCP_REGS_SVH
`define ROCP_REGS_SVH

`define ROCP_APB_AW 12
`define ROCP_CTRL_OFS 12'h000
`define ROCP_STAT_OFS 12'h004
`define ROCP_CTRL_SCLR_BIT 0
`define ROCP_CTRL_MASK 32'h0000_0001
`define ROCP_CTRL_RST 32'h0000_0000
`define ROCP_STAT_CHK_LSB 0
`define ROCP_STAT_ZERO_BIT 8
`define ROCP_STAT_STR_BIT 9
`define ROCP_PAR_W 8
`define ROCP_BYTE_W 8

`endif

// ---- rocp_pkg.sv ----
// types shared by the ram output-clear block
// assumes rocp_regs.svh is on the include path
`include "rocp_regs.svh"

package rocp_pkg;
    typedef logic [`ROCP_PAR_W-1:0] rocp_chk_t;
    typedef logic [31:0] rocp_word_t;
    typedef logic [`ROCP_APB_AW-1:0] rocp_addr_t;
endpackage : rocp_pkg

// ---- rocp_apb_regs.sv ----
// apb slave holding the control word and returning the status word of the ram block
// assumes the caller supplies an already synchronised active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "rocp_regs.svh"

module rocp_apb_regs
    import rocp_pkg::*;
(
    input wire logic mclk,
    input wire logic rstSyncN,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire rocp_addr_t paddr,
    input wire rocp_word_t pwdata,
    output rocp_word_t prdata,
    output logic pready,
    output logic pslverr,
    output logic softClear,
    input wire rocp_word_t statWord
);
    rocp_word_t ctrl_r, ctrl_nxt, prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic access, done;

    // one wait state: answer built while pready is low, write lands
    // only on the edge that completes the transfer
    always_comb begin
        access = psel & penable & ~pready_r;
        done = psel & penable & pready_r;
        ctrl_nxt = ctrl_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (access) begin
            pready_nxt = 1'b1;
            case (paddr)
                `ROCP_CTRL_OFS: prdata_nxt = ctrl_r;
                `ROCP_STAT_OFS: prdata_nxt = statWord;
                default: begin
                    prdata_nxt = 32'h0000_0000;
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        if (done && pwrite && paddr == `ROCP_CTRL_OFS) begin
            ctrl_nxt = pwdata & `ROCP_CTRL_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            ctrl_r <= `ROCP_CTRL_RST;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign softClear = ctrl_r[`ROCP_CTRL_SCLR_BIT];
endmodule : rocp_apb_regs
`default_nettype wire

// ---- rocp_ram.sv ----
// embedded ram with output clears, register clock enables, byte enables,
// address stall and check-bit injection; one clock serves both ports
// assumes fabric ports are driven from logic on mclk, except outClear
`timescale 1ns/1ps
`default_nettype none
`include "rocp_regs.svh"

// Behaviour
// - Without output registers, the async clear zeroes the data outputs.
// - The async clear may assert at any time, unrelated to the clock.
// - Each async clear pulse is stretched to the next output clock edge.
// - After an async clear the outputs stay zero until the next read.
// - A synchronous clear zeroes output latch and register on an edge.
// - Write address, data and controls load only with inClkEn high.
// - The output register loads only with outClkEn high, else holds unless a clear zeroes it.
// - Wide words write only the bytes whose byte enable bit is set.
// - Encoder bypass and 8-bit parity inputs take effect in dual-port mode only.
// - With bypass high, stored check bits are encoder XOR parity.
// - With address stall high, the address register keeps its value.
module rocp_ram
    import rocp_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 3,
    parameter bit OUT_REG = 1'b1,
    parameter bit SDP_MODE = 1'b1
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic inClkEn,
    input wire logic wrEn,
    input wire logic [DATA_W/8-1:0] byteEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic addrStall,
    input wire logic eccEncBypass,
    input wire rocp_chk_t eccParity,
    input wire logic rdEn,
    input wire logic [ADDR_W-1:0] rdAddr,
    input wire logic rdAddrStall,
    input wire logic outClkEn,
    input wire logic outClear,
    input wire logic syncClear,
    output logic [DATA_W-1:0] q,
    output rocp_chk_t qCheck,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire rocp_addr_t paddr,
    input wire rocp_word_t pwdata,
    output rocp_word_t prdata,
    output logic pready,
    output logic pslverr
);
    localparam int BYTES = DATA_W / `ROCP_BYTE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam bit BYTE_MODE = (BYTES >= 2);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rstSync_r;
    logic rstSyncN, clrN, stretch_r, softClear, anySync;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstSync_r <= 2'b00;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstSyncN = rstSync_r[1];
    // async clear acts straight on the output flops, no clock needed
    assign clrN = rstSyncN & ~outClear;

    // pulse too short to meet an edge still clears at the next edge
    always_ff @(posedge mclk or posedge outClear or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stretch_r <= 1'b0;
        end else if (outClear) begin
            stretch_r <= 1'b1;
        end else begin
            stretch_r <= 1'b0;
        end
    end
    assign anySync = syncClear | softClear | stretch_r;

    function automatic rocp_chk_t eccEncode(input logic [DATA_W-1:0] d);
        rocp_chk_t c;
        c = '0;
        for (int i = 0; i < DATA_W; i++) begin
            c[i % `ROCP_PAR_W] = c[i % `ROCP_PAR_W] ^ d[i];
        end
        return c;
    endfunction : eccEncode

    // ****************************************************************
    // write and read input registers
    // ****************************************************************
    logic [ADDR_W-1:0] wrAddr_r, wrAddr_nxt, rdAddr_r, rdAddr_nxt;
    logic [DATA_W-1:0] wrData_r, wrData_nxt;
    logic [BYTES-1:0] byteEn_r, byteEn_nxt;
    logic wrEn_r, wrEn_nxt, rdEn_r;
    rocp_chk_t wrChk_r, wrChk_nxt;
    logic bypassOn;

    // other modes simply have no injection path
    assign bypassOn = SDP_MODE & eccEncBypass;

    always_comb begin
        wrAddr_nxt = wrAddr_r;
        wrData_nxt = wrData_r;
        byteEn_nxt = byteEn_r;
        wrEn_nxt = wrEn_r;
        wrChk_nxt = wrChk_r;
        rdAddr_nxt = rdAddrStall ? rdAddr_r : rdAddr;
        if (inClkEn) begin
            if (!addrStall) begin
                wrAddr_nxt = wrAddr;
            end
            wrData_nxt = wrData;
            byteEn_nxt = byteEn;
            wrEn_nxt = wrEn;
            wrChk_nxt = eccEncode(wrData) ^ (bypassOn ? eccParity : '0);
        end
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wrAddr_r <= '0;
            wrData_r <= '0;
            byteEn_r <= '0;
            wrEn_r <= 1'b0;
            wrChk_r <= '0;
            rdAddr_r <= '0;
            rdEn_r <= 1'b0;
        end else begin
            wrAddr_r <= wrAddr_nxt;
            wrData_r <= wrData_nxt;
            byteEn_r <= byteEn_nxt;
            wrEn_r <= wrEn_nxt;
            wrChk_r <= wrChk_nxt;
            rdAddr_r <= rdAddr_nxt;
            rdEn_r <= rdEn;
        end
    end

    // ****************************************************************
    // storage, one array per byte lane and one for check bits
    // ****************************************************************
    logic [DATA_W-1:0] rdWord;
    rocp_chk_t chkMem [DEPTH];

    for (genvar b = 0; b < BYTES; b++) begin : g_lane
        logic [7:0] laneMem [DEPTH];
        logic laneWe;
        // narrow words ignore byteEn; write enable is always required
        assign laneWe = wrEn_r & (BYTE_MODE ? byteEn_r[b] : 1'b1);
        always_ff @(posedge mclk) begin
            if (laneWe) begin
                laneMem[wrAddr_r] <= wrData_r[b*8 +: 8];
            end
        end
        assign rdWord[b*8 +: 8] = laneMem[rdAddr_r];
    end

    always_ff @(posedge mclk) begin
        if (wrEn_r) begin
            chkMem[wrAddr_r] <= wrChk_r;
        end
    end

    // ****************************************************************
    // output latch and output register
    // ****************************************************************
    logic [DATA_W-1:0] latQ_r, latQ_nxt, outQ_r, outQ_nxt;
    rocp_chk_t latChk_r, latChk_nxt, outChk_r, outChk_nxt;

    always_comb begin
        latQ_nxt = latQ_r;
        latChk_nxt = latChk_r;
        outQ_nxt = outQ_r;
        outChk_nxt = outChk_r;
        if (anySync) begin
            latQ_nxt = '0;
            latChk_nxt = '0;
        end else if (rdEn_r) begin
            latQ_nxt = rdWord;
            latChk_nxt = chkMem[rdAddr_r];
        end
        if (anySync) begin
            outQ_nxt = '0;
            outChk_nxt = '0;
        end else if (outClkEn) begin
            outQ_nxt = latQ_r;
            outChk_nxt = latChk_r;
        end
    end

    // zero then holds until the next read loads new data
    always_ff @(posedge mclk or negedge clrN) begin
        if (!clrN) begin
            latQ_r <= '0;
            latChk_r <= '0;
            outQ_r <= '0;
            outChk_r <= '0;
        end else begin
            latQ_r <= latQ_nxt;
            latChk_r <= latChk_nxt;
            outQ_r <= outQ_nxt;
            outChk_r <= outChk_nxt;
        end
    end

    if (OUT_REG) begin : g_outReg
        assign q = outQ_r;
        assign qCheck = outChk_r;
    end else begin : g_outLat
        assign q = latQ_r;
        assign qCheck = latChk_r;
    end

    // ****************************************************************
    // register access
    // ****************************************************************
    rocp_word_t statWord;
    always_comb begin
        statWord = 32'h0000_0000;
        statWord[`ROCP_STAT_CHK_LSB +: `ROCP_PAR_W] = latChk_r;
        statWord[`ROCP_STAT_ZERO_BIT] = (latQ_r == '0);
        statWord[`ROCP_STAT_STR_BIT] = stretch_r;
    end

    rocp_apb_regs u_regs (
        .mclk(mclk),
        .rstSyncN(rstSyncN),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .softClear(softClear),
        .statWord(statWord)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstSyncN);

    async_clr_zero_a: assert property (
        outClear |=> latQ_r == '0 && outQ_r == '0)
        else $error("async clear did not zero outputs");
    clr_stretch_a: assert property (
        stretch_r |=> latQ_r == '0 && outQ_r == '0)
        else $error("stretched clear missed the next edge");
    zero_hold_a: assert property (
        (latQ_r == '0 && !rdEn_r) |=> latQ_r == '0)
        else $error("cleared output changed without a read");
    sync_clr_a: assert property (
        syncClear |=> latQ_r == '0 && outQ_r == '0)
        else $error("sync clear did not zero outputs");
    in_clken_a: assert property (
        !inClkEn |=> $stable(wrData_r) && $stable(wrEn_r) && $stable(wrAddr_r))
        else $error("input register moved without clock enable");
    // a clear pulse between two edges shows up as stretch at the next one
    out_clken_a: assert property (
        (!outClkEn && !anySync && !outClear) |=>
            $stable(outQ_r) || stretch_r)
        else $error("output register moved without clock enable");
    chk_inject_a: assert property (
        (inClkEn && bypassOn) |=>
            wrChk_r == (eccEncode(wrData_r) ^ $past(eccParity)))
        else $error("injected check bits wrong");
    addr_stall_a: assert property (
        (inClkEn && addrStall) |=> $stable(wrAddr_r))
        else $error("address moved during stall");
    rd_hold_a: assert property (
        (!rdEn_r && !anySync && !outClear) |=>
            $stable(latQ_r) || stretch_r)
        else $error("latch changed without read enable");
    clr_prio_a: assert property (
        (outClear && !syncClear) ##1 syncClear |-> latQ_r == '0)
        else $error("clear priority broken");

    rd_then_out_c: cover property (rdEn_r ##1 outClkEn ##1 q != '0);
    short_clr_c: cover property (stretch_r && !outClear);
    both_clr_c: cover property (outClear && syncClear);
    byte_wr_c: cover property (wrEn_r && byteEn_r != '1 && byteEn_r != '0);
endmodule : rocp_ram
`default_nettype wire

// ---- rocp_fabric_model.sv ----
// fabric-side model driving the write port of the ram block
// assumes the bench calls put at most once per clock
`timescale 1ns/1ps
`default_nettype none
module rocp_fabric
    import rocp_pkg::*;
(
    input wire logic mclk,
    output logic inClkEn,
    output logic wrEn,
    output logic [1:0] byteEn,
    output logic [2:0] wrAddr,
    output logic [15:0] wrData,
    output logic addrStall,
    output logic eccEncBypass,
    output rocp_chk_t eccParity
);
    initial begin
        {inClkEn, wrEn, addrStall, eccEncBypass} = 4'h0;
        byteEn = 2'h0;
        wrAddr = 3'h0;
        wrData = 16'h0;
        eccParity = 8'h00;
    end

    task automatic put(input logic ce, we, st, byp, input logic [1:0] be,
        input logic [2:0] a, input logic [15:0] d, input rocp_chk_t par);
        @(posedge mclk);
        inClkEn <= ce;
        wrEn <= we;
        // word is two bytes wide, so the byte mask is always live
        byteEn <= be;
        wrAddr <= a;
        wrData <= d;
        addrStall <= st;
        eccEncBypass <= byp;
        eccParity <= par;
    endtask : put
endmodule : rocp_fabric
`default_nettype wire

// ---- rocp_testbench.sv ----
// self-checking bench for the ram output-clear block
// assumes rocp_fabric drives the write port; apb and read port driven here
`timescale 1ns/1ps
`default_nettype none
`include "rocp_regs.svh"
module testbench;
    import rocp_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic inClkEn, wrEn, addrStall, eccEncBypass, pready, pslverr, rerr;
    logic [1:0] byteEn;
    logic [2:0] wrAddr, la;
    logic [2:0] rdAddr = 3'h0;
    logic [15:0] wrData, q;
    rocp_chk_t eccParity, qCheck;
    logic rdEn = 1'b0, rdAddrStall = 1'b0, outClkEn = 1'b0;
    logic outClear = 1'b0, syncClear = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    rocp_addr_t paddr = 12'h000;
    rocp_word_t pwdata = 32'h0, prdata, rdat;
    int err_total = 0;
    int checks = 0;
    logic [31:0] rnd = 32'hd9db;
    logic [15:0] mem [8];
    rocp_chk_t ck [8];
    logic cv [8];

    rocp_fabric fab(.mclk(mclk), .inClkEn(inClkEn), .wrEn(wrEn),
        .byteEn(byteEn), .wrAddr(wrAddr), .wrData(wrData),
        .addrStall(addrStall), .eccEncBypass(eccEncBypass),
        .eccParity(eccParity));
    rocp_ram #(.DATA_W(16), .ADDR_W(3), .OUT_REG(1'b1), .SDP_MODE(1'b1))
    dut(.mclk(mclk), .rstn(rstn), .inClkEn(inClkEn), .wrEn(wrEn),
        .byteEn(byteEn), .wrAddr(wrAddr), .wrData(wrData),
        .addrStall(addrStall), .eccEncBypass(eccEncBypass),
        .eccParity(eccParity), .rdEn(rdEn), .rdAddr(rdAddr),
        .rdAddrStall(rdAddrStall), .outClkEn(outClkEn),
        .outClear(outClear), .syncClear(syncClear), .q(q),
        .qCheck(qCheck), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx

    function automatic rocp_chk_t enc(input logic [15:0] d);
        rocp_chk_t c;
        c = 8'h00;
        for (int i = 0; i < 16; i++) c[i % 8] ^= d[i];
        return c;
    endfunction : enc

    task automatic results;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t %s", $time, m);
            err_total++;
        end
    endtask : chk

    // keeps the expected image; the address register survives a stall
    task automatic wr(input logic ce, we, st, byp, input logic [1:0] be,
        input logic [2:0] a, input logic [15:0] d, input rocp_chk_t par);
        fab.put(ce, we, st, byp, be, a, d, par);
        if (ce) begin
            if (!st) la = a;
            if (we) begin
                for (int b = 0; b < 2; b++)
                    if (be[b]) mem[la][8*b+:8] = d[8*b+:8];
                cv[la] = (be == 2'b11);
                ck[la] = enc(d) ^ (byp ? par : 8'h00);
            end
        end
    endtask : wr

    task automatic apb(input logic w, input rocp_addr_t a, rocp_word_t d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            results();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // q is due at the third edge after the request edge
    task automatic rd(input logic [2:0] a, input logic oce);
        @(posedge mclk);
        rdEn <= 1'b1;
        rdAddr <= a;
        outClkEn <= oce;
        @(posedge mclk);
        rdEn <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : rd

    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, `ROCP_CTRL_OFS, 32'h0);
        chk(rdat, `ROCP_CTRL_RST, "ctrl reset value");
        for (int i = 0; i < 8; i++) begin
            rnd = nx(rnd);
            wr(1'b1, 1'b1, 1'b0, rnd[0], 2'b11, i[2:0], rnd[23:8],
                rnd[31:24]);
        end
        for (int i = 0; i < 40; i++) begin
            rnd = nx(rnd);
            wr(rnd[0] | rnd[1], rnd[2] | rnd[3], rnd[6] & rnd[7], rnd[5],
                rnd[5:4], rnd[10:8] ^ rnd[30:28], rnd[23:8], rnd[31:24]);
        end
        wr(1'b1, 1'b0, 1'b0, 1'b0, 2'b11, la, 16'hffff, 8'h00);
        wr(1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 3'h0, 16'h0, 8'h00);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], 1'b1);
            chk({16'h0, q}, {16'h0, mem[a]}, "read data");
            if (cv[a]) chk({24'h0, qCheck}, {24'h0, ck[a]}, "check bits");
        end
        rd(3'h0, 1'b1);
        rd(3'h1, 1'b0);
        chk({16'h0, q}, {16'h0, mem[0]}, "output register held");
        rd(3'h1, 1'b1);
        // a read is on its way into the latch when the pulse comes
        @(posedge mclk);
        rdEn <= 1'b1;
        @(posedge mclk);
        rdEn <= 1'b0;
        #10 outClear = 1'b1;
        #5 chk({16'h0, q}, 32'h0, "async clear");
        outClear = 1'b0;
        @(posedge mclk);
        #1 chk({16'h0, q}, 32'h0, "clear stretched");
        repeat (3) @(posedge mclk);
        #1 chk({16'h0, q}, 32'h0, "cleared until read");
        rd(3'h1, 1'b1);
        chk({16'h0, q}, {16'h0, mem[1]}, "read after clear");
        @(posedge mclk);
        outClkEn <= 1'b0;
        syncClear <= 1'b1;
        @(posedge mclk);
        syncClear <= 1'b0;
        #1 chk({16'h0, q}, 32'h0, "sync clear");
        rd(3'h2, 1'b1);
        outClear = 1'b1;
        @(posedge mclk);
        syncClear <= 1'b1;
        @(posedge mclk);
        syncClear <= 1'b0;
        #1 chk({16'h0, q}, 32'h0, "both clears");
        outClear = 1'b0;
        rd(3'h3, 1'b1);
        apb(1'b1, `ROCP_CTRL_OFS, 32'h1);
        repeat (2) @(posedge mclk);
        #1 chk({16'h0, q}, 32'h0, "soft sync clear");
        apb(1'b0, `ROCP_CTRL_OFS, 32'h0);
        chk(rdat, 32'h1, "ctrl readback");
        apb(1'b1, `ROCP_CTRL_OFS, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        chk(rdat, 32'h0, "unmapped data");
        apb(1'b0, `ROCP_STAT_OFS, 32'h0);
        chk({31'h0, rerr}, 32'h0, "status access");
        chk(rdat, 32'h1 << `ROCP_STAT_ZERO_BIT, "status zero flag");
        rd(3'h3, 1'b1);
        chk({16'h0, q}, {16'h0, mem[3]}, "read after soft clear");
        @(posedge mclk);
        rdAddrStall <= 1'b1;
        rd(3'h5, 1'b1);
        chk({16'h0, q}, {16'h0, mem[3]}, "read address stall");
        rdAddrStall <= 1'b0;
        results();
    end
endmodule : testbench
`default_nettype wire
